/* common/auto_restart_pkg.sv */
// package: constants and types for the automatic restart sequencer
package auto_restart_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned TENTH_SEC_NS      = 100_000_000;
  localparam int unsigned TENTH_CYCLES      = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_SEC       = 30;
  localparam logic [9:0]  RECOVER_TENTHS    = 10'(RECOVER_SEC * 10);

  // ----------------------------------------------------------------
  // setting ranges and values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0]  LIMIT_MAX         = 4'ha;
  localparam logic [3:0]  LIMIT_RESET       = 4'h0;
  localparam logic [9:0]  DELAY_MAX_TENTHS  = 10'h258;
  localparam logic [9:0]  DELAY_RESET       = 10'h00a;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 16;
  localparam logic [7:0]  ADDR_LIMIT        = 8'h00;
  localparam logic [7:0]  ADDR_DELAY        = 8'h04;
  localparam logic [7:0]  ADDR_STATE        = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h10;

  // state register fields
  localparam int unsigned STATE_REMAIN_LSB  = 0;
  localparam int unsigned STATE_FSM_LSB     = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;          // one-cycle trip event
    logic undervoltage;   // cause qualifier, read with valid
  } trip_t;

  typedef struct packed {
    logic suppressed;     // restart forbidden by trip cause or by emergency stop in ST_DELAY
    logic recovered;      // count restored after quiet window
    logic exhausted;      // trip with no attempts left
    logic restarted;      // restart request issued
  } irq_bits_t;

  localparam int unsigned IRQ_W             = $bits(irq_bits_t);

  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_DELAY   = 4'h2,
    ST_WATCH   = 4'h4,
    ST_LOCKED  = 4'h8
  } rs_state_t;

endpackage : auto_restart_pkg

/* dv/auto_restart_ctrl_chk.sv */
// checker: port level properties of the restart sequencer
`timescale 1ns/100ps
module auto_restart_ctrl_chk #(
  parameter int unsigned TENTH_CYCLES = 4
) (
  input wire logic               clk_sys_in,               // system clock
  input wire logic               rstn_in,                  // async reset, active low
  input auto_restart_pkg::trip_t trip_in,                  // trip event and cause
  input wire logic               emergency_stop_input_in,  // stop pin
  input wire logic               reset_terminal_in,        // fault reset terminal
  input wire logic               reset_key_in,             // keypad reset key
  input wire logic [7:0]         addr_in,                  // register address
  input wire logic [15:0]        wr_data_in,               // write data
  input wire logic               wr_in,                    // write strobe
  input wire logic               rd_in,                    // read strobe
  input wire logic [15:0]        rd_data_out,              // read data
  input wire logic               speed_search_restart_out, // restart pulse
  input wire logic               restart_locked_out,       // locked level
  input wire logic               irq_out                   // interrupt
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  a_locked_no_restart: assert property (restart_locked_out |-> !speed_search_restart_out)
    else $error("restart request while locked");
  a_restart_single: assert property (speed_search_restart_out |=> !speed_search_restart_out)
    else $error("restart request longer than one cycle");
  a_uv_trip_locks: assert property (trip_in.valid && trip_in.undervoltage |=> restart_locked_out)
    else $error("undervoltage trip did not lock");
  a_estop_trip_locks: assert property (
    emergency_stop_input_in [*4] ##0 trip_in.valid |=> restart_locked_out)
    else $error("trip under emergency stop did not lock");
  a_trip_waits_delay: assert property (
    trip_in.valid && !restart_locked_out |=> !speed_search_restart_out)
    else $error("restart without any delay stage");
  a_reset_unlocks: assert property (
    restart_locked_out && $rose(reset_key_in || reset_terminal_in) |-> ##[1:6] !restart_locked_out)
    else $error("fault reset did not unlock");
  a_unlock_by_reset: assert property (
    $fell(restart_locked_out) |-> $past(reset_key_in || reset_terminal_in, 2))
    else $error("unlocked without fault reset");
  a_read_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 16'h0000)
    else $error("read data outside read answer");
endmodule : auto_restart_ctrl_chk

/* dv/testbench.sv */
// testbench: corner and random trips against the restart sequencer
`timescale 1ns/100ps
module testbench;
  localparam int unsigned TC = 4;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic fire = 1'b0, uv = 1'b0, estop = 1'b0, rkey = 1'b0, rterm = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rd_data;
  logic pulse, locked, irq;
  logic [7:0] restarts;
  auto_restart_pkg::trip_t trip;
  int num_errors = 0, comparisons = 0, cycles = 0, n, lim, dly;
  always #5 clk_sys_in = ~clk_sys_in;

  trip_model i_trip_model (.clk_sys_in, .rstn_in, .fire_in(fire), .uv_in(uv),
    .restart_in(pulse), .trip_out(trip), .restarts_out(restarts));
  auto_restart_ctrl #(.TENTH_CYCLES(TC)) i_auto_restart_ctrl (.clk_sys_in, .rstn_in,
    .trip_in(trip), .emergency_stop_input_in(estop), .reset_terminal_in(rterm),
    .reset_key_in(rkey), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rd_data), .speed_search_restart_out(pulse), .restart_locked_out(locked),
    .irq_out(irq));

  function automatic logic [15:0] st(input logic [3:0] s, input logic [3:0] r);
    return {8'h00, s, r};
  endfunction : st
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk(what, exp, rd_data);
  endtask : rchk
  // n is the cycle count to the restart request, -1 when none came within max
  task automatic do_trip(input logic c, input int max, output int n);
    @(posedge clk_sys_in);
    fire <= 1'b1;
    uv <= c;
    @(posedge clk_sys_in);
    fire <= 1'b0;
    n = -1;
    for (int i = 1; i <= max && n < 0; i++) begin
      @(posedge clk_sys_in);
      #1 if (pulse === 1'b1) n = i;
    end
  endtask : do_trip
  // pins pass a two flop synchroniser, so hold well past it
  task automatic freset(input logic term);
    @(posedge clk_sys_in);
    if (term) rterm <= 1'b1;
    else rkey <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rterm <= 1'b0;
    rkey <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask : freset
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    n = $urandom(46573);
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rchk("limit", auto_restart_pkg::ADDR_LIMIT, 16'h0000);
    rchk("delay", auto_restart_pkg::ADDR_DELAY, 16'h000a);
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_RUN, 4'h0));
    rchk("unmapped", 8'h14, 16'h0000);
    $display("test reset values done");
    do_trip(1'b0, 12, n);
    chk("restart", 16'hffff, 16'(n));
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_LOCKED, 4'h0));
    rchk("status", auto_restart_pkg::ADDR_IRQ_STATUS, 16'h0002);
    wreg(auto_restart_pkg::ADDR_IRQ_MASK, 16'h0002);
    @(posedge clk_sys_in);
    #1 chk("irq", 16'h0001, 16'(irq));
    wreg(auto_restart_pkg::ADDR_IRQ_STATUS, 16'h0002);
    @(posedge clk_sys_in);
    #1 chk("irq", 16'h0000, 16'(irq));
    $display("test zero limit done");
    wreg(auto_restart_pkg::ADDR_LIMIT, 16'h000f);
    rchk("limit", auto_restart_pkg::ADDR_LIMIT, 16'h000a);
    wreg(auto_restart_pkg::ADDR_DELAY, 16'h03ff);
    rchk("delay", auto_restart_pkg::ADDR_DELAY, 16'h0258);
    wreg(auto_restart_pkg::ADDR_LIMIT, 16'h0002);
    wreg(auto_restart_pkg::ADDR_DELAY, 16'h0000);
    wreg(auto_restart_pkg::ADDR_IRQ_MASK, 16'h000f);
    freset(1'b0);
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_RUN, 4'h2));
    for (int i = 0; i < 3; i++) begin
      do_trip(1'b0, 12, n);
      chk("restart", 16'(i < 2), 16'(n > 0));
      rchk("state", auto_restart_pkg::ADDR_STATE, (i < 2) ? st(auto_restart_pkg::ST_WATCH,
        4'(1 - i)) : st(auto_restart_pkg::ST_LOCKED, 4'h0));
      chk("irq", 16'h0001, 16'(irq));
      wreg(auto_restart_pkg::ADDR_IRQ_STATUS, 16'h000f);
    end
    chk("restarts", 16'h0002, 16'(restarts));
    $display("test attempt count done");
    freset(1'b1);
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_RUN, 4'h2));
    do_trip(1'b1, 12, n);
    chk("restart", 16'hffff, 16'(n));
    rchk("status", auto_restart_pkg::ADDR_IRQ_STATUS, 16'h0008);
    wreg(auto_restart_pkg::ADDR_IRQ_STATUS, 16'h000f);
    freset(1'b0);
    @(posedge clk_sys_in);
    estop <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    do_trip(1'b0, 12, n);
    chk("locked", 16'h0001, 16'(locked));
    @(posedge clk_sys_in);
    estop <= 1'b0;
    wreg(auto_restart_pkg::ADDR_IRQ_STATUS, 16'h000f);
    $display("test suppressed causes done");
    lim = 1 + $urandom % 10;
    dly = 1 + $urandom % 5;
    wreg(auto_restart_pkg::ADDR_LIMIT, 16'(lim));
    wreg(auto_restart_pkg::ADDR_DELAY, 16'(dly));
    freset(1'b0);
    do_trip(1'b0, 40, n);
    chk("delay", 16'h0001, 16'(n >= dly * TC && n <= dly * TC + 4));
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_WATCH, 4'(lim - 1)));
    // just short of the quiet window the count must not be restored yet
    repeat (auto_restart_pkg::RECOVER_TENTHS * TC - 50) @(posedge clk_sys_in);
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_WATCH, 4'(lim - 1)));
    repeat (50) @(posedge clk_sys_in);
    rchk("state", auto_restart_pkg::ADDR_STATE, st(auto_restart_pkg::ST_RUN, 4'(lim)));
    rchk("status", auto_restart_pkg::ADDR_IRQ_STATUS, 16'h0005);
    $display("test random delay and recovery done");
    end_sim();
  end
endmodule : testbench

bind auto_restart_ctrl auto_restart_ctrl_chk #(.TENTH_CYCLES(TENTH_CYCLES)) i_chk (
  .clk_sys_in, .rstn_in, .trip_in, .emergency_stop_input_in, .reset_terminal_in,
  .reset_key_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
  .speed_search_restart_out, .restart_locked_out, .irq_out);

/* dv/trip_model.sv */
// partner model: drive protection that raises trips and counts restart requests
`timescale 1ns/100ps
module trip_model (
  input  wire logic               clk_sys_in,   // system clock
  input  wire logic               rstn_in,      // async reset, active low
  input  wire logic               fire_in,      // bench asks for one trip
  input  wire logic               uv_in,        // cause of that trip
  input  wire logic               restart_in,   // restart request seen
  output auto_restart_pkg::trip_t trip_out,     // trip event to the sequencer
  output logic [7:0]              restarts_out  // restart requests counted
);
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trip_out     <= '0;
      restarts_out <= 8'h00;
    end else begin
      trip_out.valid        <= fire_in;
      // the cause means nothing without valid, so keep it moving to expose misuse
      trip_out.undervoltage <= fire_in ? uv_in : ~trip_out.undervoltage;
      restarts_out          <= restarts_out + 8'(restart_in);
    end
  end
endmodule : trip_model

/* src/auto_restart_ctrl.sv */
// automatic restart sequencer after protective trips
//
// Operation
// - hold restart attempt limit, 0 to 10, reset 0
// - wait programmed delay, 0 to 60 s, before restart
// - each restart decrements remaining attempts by one
// - trips beyond the limit stop auto restart
// - terminal or key fault reset reloads attempts
// - 30 s without trip after restart reloads attempts
// - no restart after emergency stop, or after an undervoltage trip in ST_RUN or ST_WATCH
// - restart runs through speed search, not zero
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module auto_restart_ctrl #(
  parameter int unsigned TENTH_CYCLES = auto_restart_pkg::TENTH_CYCLES
) (
  input  wire logic                    clk_sys_in,             // system clock, 100 mhz
  input  wire logic                    rstn_in,                // async reset, active low
  input  auto_restart_pkg::trip_t      trip_in,                // trip event and cause
  input  wire logic                    emergency_stop_input_in, // pin, high = stop
  input  wire logic                    reset_terminal_in,      // pin, fault reset terminal
  input  wire logic                    reset_key_in,           // pin, keypad stop/reset key
  input  wire logic [7:0]              addr_in,                // register byte address
  input  wire logic [15:0]             wr_data_in,             // register write data
  input  wire logic                    wr_in,                  // write strobe
  input  wire logic                    rd_in,                  // read strobe
  output logic [15:0]                  rd_data_out,            // read data, cycle after rd_in
  output logic                         speed_search_restart_out, // restart request pulse
  output logic                         restart_locked_out,     // stopped, reset needed
  output logic                         irq_out                 // level interrupt
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] estop_sync;
  logic [1:0] term_sync;
  logic [1:0] key_sync;
  logic       term_prev;
  logic       key_prev;
  logic       fault_reset;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      estop_sync <= 2'h0;
      term_sync  <= 2'h0;
      key_sync   <= 2'h0;
      term_prev  <= 1'b0;
      key_prev   <= 1'b0;
    end else begin
      estop_sync <= {estop_sync[0], emergency_stop_input_in};
      term_sync  <= {term_sync[0], reset_terminal_in};
      key_sync   <= {key_sync[0], reset_key_in};
      term_prev  <= term_sync[1];
      key_prev   <= key_sync[1];
    end
  end

  // a held key counts once, on its press
  assign fault_reset = (term_sync[1] & ~term_prev) | (key_sync[1] & ~key_prev);

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  logic [3:0]                   restart_attempt_limit;
  logic [9:0]                   restart_delay_time;
  logic [3:0]                   next_limit;
  logic [9:0]                   next_delay;
  auto_restart_pkg::irq_bits_t  irq_mask;
  auto_restart_pkg::irq_bits_t  next_irq_mask;
  logic                         wr_limit;
  logic                         wr_delay;

  assign wr_limit = wr_in && (addr_in == auto_restart_pkg::ADDR_LIMIT);
  assign wr_delay = wr_in && (addr_in == auto_restart_pkg::ADDR_DELAY);

  always_comb begin
    next_limit    = restart_attempt_limit;
    next_delay    = restart_delay_time;
    next_irq_mask = irq_mask;
    // out-of-range settings saturate at the top of the range
    if (wr_limit) begin
      if (wr_data_in[3:0] > auto_restart_pkg::LIMIT_MAX || wr_data_in[15:4] != 12'h000) begin
        next_limit = auto_restart_pkg::LIMIT_MAX;
      end else begin
        next_limit = wr_data_in[3:0];
      end
    end
    if (wr_delay) begin
      if (wr_data_in > 16'(auto_restart_pkg::DELAY_MAX_TENTHS)) begin
        next_delay = auto_restart_pkg::DELAY_MAX_TENTHS;
      end else begin
        next_delay = wr_data_in[9:0];
      end
    end
    if (wr_in && addr_in == auto_restart_pkg::ADDR_IRQ_MASK) begin
      next_irq_mask = wr_data_in[auto_restart_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      restart_attempt_limit <= auto_restart_pkg::LIMIT_RESET;
      restart_delay_time    <= auto_restart_pkg::DELAY_RESET;
      irq_mask              <= '0;
    end else begin
      restart_attempt_limit <= next_limit;
      restart_delay_time    <= next_delay;
      irq_mask              <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic tick;
  logic tick_clear;

  tenth_tick #(
    .CYCLES     (TENTH_CYCLES)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .clear_in   (tick_clear),
    .tick_out   (tick)
  );

  // ----------------------------------------------------------------
  // restart sequencer
  // ----------------------------------------------------------------
  auto_restart_pkg::rs_state_t  state;
  auto_restart_pkg::rs_state_t  next_state;
  logic [3:0]                   remaining;
  logic [3:0]                   next_remaining;
  logic [9:0]                   timer;
  logic [9:0]                   next_timer;
  logic                         next_restart;
  auto_restart_pkg::irq_bits_t  event_set;
  logic                         trip_blocked;

  // undervoltage or a live emergency stop forbid a restart
  assign trip_blocked = trip_in.undervoltage | estop_sync[1];

  always_comb begin
    next_state     = state;
    next_remaining = remaining;
    next_timer     = timer;
    next_restart   = 1'b0;
    event_set      = '0;
    tick_clear     = 1'b0;
    if (fault_reset) begin
      next_remaining = restart_attempt_limit;
      next_state     = auto_restart_pkg::ST_RUN;
    end
    case (state)
      auto_restart_pkg::ST_DELAY: begin
        if (estop_sync[1]) begin
          next_state       = auto_restart_pkg::ST_LOCKED;
          event_set.suppressed = 1'b1;
        end else if (fault_reset) begin
          next_state = auto_restart_pkg::ST_RUN;
        end else if (timer == 10'h000) begin
          next_restart   = 1'b1;
          next_remaining = remaining - 4'h1;
          next_timer     = auto_restart_pkg::RECOVER_TENTHS;
          tick_clear     = 1'b1;
          next_state     = auto_restart_pkg::ST_WATCH;
          event_set.restarted = 1'b1;
        end else if (tick) begin
          next_timer = timer - 10'h001;
        end
      end
      auto_restart_pkg::ST_WATCH: begin
        if (!fault_reset && tick) begin
          if (timer == 10'h001) begin
            next_remaining = restart_attempt_limit;
            next_state     = auto_restart_pkg::ST_RUN;
            event_set.recovered = 1'b1;
          end else begin
            next_timer = timer - 10'h001;
          end
        end
      end
      auto_restart_pkg::ST_RUN,
      auto_restart_pkg::ST_LOCKED: begin
      end
      default: begin
        next_state = auto_restart_pkg::ST_LOCKED;
      end
    endcase
    // a trip in ST_RUN or ST_WATCH is taken last so it wins over a fault reset in the same cycle
    if (trip_in.valid && (state == auto_restart_pkg::ST_RUN ||
                          state == auto_restart_pkg::ST_WATCH)) begin
      next_restart = 1'b0;
      if (trip_blocked) begin
        next_state           = auto_restart_pkg::ST_LOCKED;
        event_set.suppressed = 1'b1;
      end else if (next_remaining == 4'h0) begin
        next_state          = auto_restart_pkg::ST_LOCKED;
        event_set.exhausted = 1'b1;
      end else begin
        next_state = auto_restart_pkg::ST_DELAY;
        next_timer = restart_delay_time;
        tick_clear = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state                    <= auto_restart_pkg::ST_RUN;
      remaining                <= auto_restart_pkg::LIMIT_RESET;
      timer                    <= 10'h000;
      speed_search_restart_out <= 1'b0;
      restart_locked_out       <= 1'b0;
    end else begin
      state                    <= next_state;
      remaining                <= next_remaining;
      timer                    <= next_timer;
      speed_search_restart_out <= next_restart;
      restart_locked_out       <= (next_state == auto_restart_pkg::ST_LOCKED);
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  auto_restart_pkg::irq_bits_t  irq_status;
  auto_restart_pkg::irq_bits_t  next_irq_status;
  logic                         next_irq;

  always_comb begin
    next_irq_status = irq_status;
    if (wr_in && addr_in == auto_restart_pkg::ADDR_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wr_data_in[auto_restart_pkg::IRQ_W-1:0];
    end
    // set after clear: an event in the clearing cycle is kept
    next_irq_status = next_irq_status | event_set;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_status <= '0;
      irq_out    <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_out    <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [15:0] next_rd_data;

  always_comb begin
    next_rd_data = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        auto_restart_pkg::ADDR_LIMIT:      next_rd_data = {12'h000, restart_attempt_limit};
        auto_restart_pkg::ADDR_DELAY:      next_rd_data = {6'h00, restart_delay_time};
        auto_restart_pkg::ADDR_STATE:      next_rd_data = {8'h00, state, remaining};
        auto_restart_pkg::ADDR_IRQ_STATUS: next_rd_data = {12'h000, irq_status};
        auto_restart_pkg::ADDR_IRQ_MASK:   next_rd_data = {12'h000, irq_mask};
        default:                           next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      rd_data_out <= next_rd_data;
    end
  end

endmodule : auto_restart_ctrl

/* src/tenth_tick.sv */
// tick generator: one pulse per tenth of a second, restartable
`timescale 1ns/100ps
module tenth_tick #(
  parameter int unsigned CYCLES = auto_restart_pkg::TENTH_CYCLES
) (
  input  wire logic clk_sys_in,   // system clock
  input  wire logic rstn_in,      // async reset, active low
  input  wire logic clear_in,     // restart the period
  output logic      tick_out      // one-cycle pulse each period
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  always_comb begin
    next_count = count + 1'b1;
    next_tick  = 1'b0;
    if (clear_in) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule : tenth_tick
